// File: hw/mdu_pkg.sv
// constants shared by the multiplier/divider unit and its helpers
package mdu_pkg;

   // operation field, bits 3..0 of the mode word
   localparam logic [3:0] OP_CLEAR  = 4'h0;
   localparam logic [3:0] OP_LOAD16 = 4'h1;
   localparam logic [3:0] OP_LOAD32 = 4'h2;
   localparam logic [3:0] OP_READ   = 4'h3;
   localparam logic [3:0] OP_MULU   = 4'h4;
   localparam logic [3:0] OP_MULS   = 4'h5;
   localparam logic [3:0] OP_MAC    = 4'h7;
   localparam logic [3:0] OP_DIVU   = 4'h8;
   localparam logic [3:0] OP_DIVS   = 4'h9;

   // mode word layout
   localparam int         MODE_W       = 7;
   localparam int         MODE_OP_LSB  = 0;
   localparam int         MODE_OP_MSB  = 3;
   localparam int         MODE_OUT_LSB = 4;
   localparam int         MODE_OUT_MSB = 6;
   localparam logic [2:0] OUT_LOW      = 3'h0;
   localparam logic [2:0] OUT_HIGH     = 3'h1;
   localparam logic [6:0] MODE_RESET   = 7'h00;

   // condition flag set, order C V Z N
   localparam logic [3:0] FLAGS_NONE = 4'h0;
   localparam logic [3:0] FLAGS_OVF  = 4'h4;

   localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

   // register map, byte addresses
   localparam logic [4:0] ADDR_MODE   = 5'h00;
   localparam logic [4:0] ADDR_RESULT = 5'h04;
   localparam logic [4:0] ADDR_STATUS = 5'h08;
   localparam logic [4:0] ADDR_CLEAR  = 5'h0C;
   localparam logic [4:0] ADDR_ENABLE = 5'h10;
   localparam logic [4:0] ADDR_STATE  = 5'h14;

   // event bits of status, clear and enable
   localparam int         EV_W      = 3;
   localparam int         EV_DONE   = 0;
   localparam int         EV_OVF    = 1;
   localparam int         EV_DZERO  = 2;
   localparam logic [2:0] EV_RESET  = 3'h0;

endpackage : mdu_pkg

// File: hw/mdu_data_if.sv
// operand and result carrier between the control block and its datapaths
`timescale 1ns/10ps
`default_nettype none
interface mdu_data_if;
   logic        is_signed;
   logic [15:0] opnd_a;
   logic [15:0] opnd_b;
   logic [31:0] acc;
   logic [15:0] quot;
   logic [15:0] rem;
   logic        div_zero;
   logic [31:0] prod;
   logic [31:0] sum;
   logic        sum_ovf;

   modport ctrl (output is_signed, opnd_a, opnd_b, acc,
                 input  quot, rem, div_zero, prod, sum, sum_ovf);
   modport div  (input  is_signed, opnd_a, opnd_b,
                 output quot, rem, div_zero);
   modport mac  (input  is_signed, opnd_a, opnd_b, acc,
                 output prod, sum, sum_ovf);
endinterface : mdu_data_if
`default_nettype wire

// File: hw/mdu_divider.sv
// combinational 16 by 16 divider, unsigned or truncating signed
`timescale 1ns/10ps
`default_nettype none
module mdu_divider
   import mdu_pkg::*;
(
   mdu_data_if.div dio
);
   logic        neg_a;
   logic        neg_b;
   logic [15:0] mag_a;
   logic [15:0] mag_b;
   logic [15:0] uq;
   logic [15:0] ur;

   assign neg_a = dio.is_signed & dio.opnd_a[15];
   assign neg_b = dio.is_signed & dio.opnd_b[15];
   assign mag_a = neg_a ? 16'(-dio.opnd_a) : dio.opnd_a;
   assign mag_b = neg_b ? 16'(-dio.opnd_b) : dio.opnd_b;
   assign dio.div_zero = (dio.opnd_b == 16'h0000);
   // zero divisor: all-ones quotient, 0x0001 for a negative signed dividend; dividend kept as residue
   assign uq = dio.div_zero ? 16'hFFFF : 16'(mag_a / mag_b);
   assign ur = dio.div_zero ? mag_a : 16'(mag_a % mag_b);
   assign dio.quot = (neg_a ^ neg_b) ? 16'(-uq) : uq;
   assign dio.rem  = neg_a ? 16'(-ur) : ur;
endmodule : mdu_divider
`default_nettype wire

// File: hw/mdu_mac.sv
// product and accumulate sum with signed overflow detect
`timescale 1ns/10ps
`default_nettype none
module mdu_mac
   import mdu_pkg::*;
(
   mdu_data_if.mac mio
);
   logic [31:0] sprod;
   logic [31:0] uprod;

   // operands widened first so the product keeps all 32 bits
   assign sprod = $signed({{16{mio.opnd_a[15]}}, mio.opnd_a})
                * $signed({{16{mio.opnd_b[15]}}, mio.opnd_b});
   assign uprod = {16'h0000, mio.opnd_a} * {16'h0000, mio.opnd_b};
   assign mio.prod = mio.is_signed ? sprod : uprod;
   // accumulation is always signed
   assign mio.sum  = 32'(sprod + mio.acc);
   assign mio.sum_ovf = (~sprod[31] & ~mio.acc[31] & mio.sum[31])
                      | (sprod[31] & mio.acc[31] & ~mio.sum[31]);
endmodule : mdu_mac
`default_nettype wire

// File: hw/mdu_unit.sv
// multiplier/divider coprocessor: divide, initialise, accumulate, bus regs
//
// What this block does
// - mode 0x8 divides unsigned, 0x9 signed; first operand dividend
// - division stores quotient in result low half, residue high half
// - division answer is quotient or residue per output half; flags zero
// - result register holds its value until a later operation
// - writing mode 0x0 clears the result register at once
// - load: mode 0x1 zero-extends source, mode 0x2 loads both operands
// - mode 0x7 adds the signed product to the result register
// - accumulate answer is low or high result half per output field
// - accumulate flags are 0b0100 on overflow, else all zero
// - accumulate mode stays set for repeated operand pairs
// - overflow: like-signed product and result give opposite sign sum
// - overflow clears on clean accumulate or transfer outside read mode
// - mode word: bits 6..4 output half, bits 3..0 operation
// - read mode returns selected half, no change, flags zero
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module mdu_unit
   import mdu_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        rstn_in,
   // cpu coprocessor side
   input  wire logic        mode_wr_in,
   input  wire logic [6:0]  mode_data_in,
   input  wire logic        operate_wr_in,
   input  wire logic        load_wr_in,
   input  wire logic [15:0] dst_opnd_in,
   input  wire logic [15:0] src_opnd_in,
   output logic             ans_valid_out,
   output logic [15:0]      ans_data_out,
   output logic [3:0]       flags_out,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic             irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // state

   logic [6:0]  mode_reg;
   logic [6:0]  mode_next;
   logic [31:0] result_reg;
   logic [31:0] result_next;
   logic        ovf_reg;
   logic        ovf_next;
   logic        ans_valid_reg;
   logic [15:0] ans_data_reg;
   logic [15:0] ans_data_next;
   logic [3:0]  flags_reg;
   logic [3:0]  flags_next;
   logic [2:0]  status_reg;
   logic [2:0]  status_next;
   logic [2:0]  enable_reg;
   logic [2:0]  enable_next;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   mdu_data_if dp ();

   mdu_divider u_div
   (
      .dio (dp.div)
   );

   mdu_mac u_mac
   (
      .mio (dp.mac)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode of mode and strobes

   wire [3:0]  op_code;
   wire [2:0]  out_field;
   wire        high_sel;
   wire        is_div;
   wire        is_mac;
   wire        is_mul;
   wire        do_op;
   wire        do_load;
   wire        counts_for_ovf;
   wire        op_ovf;
   wire        is_read;
   wire        is_load16;
   wire        is_load32;

   assign op_code   = mode_reg[MODE_OP_MSB:MODE_OP_LSB];
   assign out_field = mode_reg[MODE_OUT_MSB:MODE_OUT_LSB];
   // reserved output codes fall back to the low half
   assign high_sel  = (out_field == OUT_HIGH);
   assign is_div    = (op_code == OP_DIVU) | (op_code == OP_DIVS);
   // mode is never rewritten by an operate, so accumulate repeats
   assign is_mac    = (op_code == OP_MAC);
   assign is_mul    = (op_code == OP_MULU) | (op_code == OP_MULS);
   // a mode write in the same cycle wins over the operand strobes
   assign do_op     = operate_wr_in & ~mode_wr_in;
   assign do_load   = load_wr_in & ~mode_wr_in & ~operate_wr_in;
   assign is_read   = (op_code == OP_READ);
   assign is_load16 = (op_code == OP_LOAD16);
   assign is_load32 = (op_code == OP_LOAD32);
   // read mode leaves the overflow flag alone so it can be polled
   assign counts_for_ovf = (do_op | do_load) & ~is_read;
   assign op_ovf    = do_op & is_mac & dp.sum_ovf;

   ////////////////////////////////////////////////////////////////////////
   // datapath operands

   assign dp.is_signed = (op_code == OP_DIVS) | (op_code == OP_MULS);
   assign dp.opnd_a    = dst_opnd_in;
   assign dp.opnd_b    = src_opnd_in;
   assign dp.acc       = result_reg;

   ////////////////////////////////////////////////////////////////////////
   // avalon-mm decode

   wire        bus_req;
   wire        cpu_busy;
   wire        bus_fire;
   wire        wr_fire;
   wire        be_low;
   wire        wr_mode;
   wire        wr_clear;
   wire        wr_enable;
   wire [2:0]  clear_bits;
   wire        hit_mode;
   wire        hit_result;
   wire        hit_status;
   wire        hit_enable;
   wire        hit_clear;
   wire        hit_state;

   assign bus_req  = avs_read_in | avs_write_in;
   // bus accesses wait out cpu strobes so the two never collide
   assign cpu_busy = mode_wr_in | operate_wr_in | load_wr_in;
   assign bus_fire = bus_req & ack_reg & ~cpu_busy;
   assign wr_fire  = bus_fire & avs_write_in;
   assign be_low   = avs_byteenable_in[0];

   assign hit_mode   = (avs_address_in == ADDR_MODE);
   assign hit_result = (avs_address_in == ADDR_RESULT);
   assign hit_status = (avs_address_in == ADDR_STATUS);
   assign hit_enable = (avs_address_in == ADDR_ENABLE);
   assign hit_clear  = (avs_address_in == ADDR_CLEAR);
   assign hit_state  = (avs_address_in == ADDR_STATE);

   assign wr_mode   = wr_fire & be_low & hit_mode;
   assign wr_clear  = wr_fire & be_low & hit_clear;
   assign wr_enable = wr_fire & be_low & hit_enable;
   assign clear_bits = wr_clear ? avs_writedata_in[EV_W-1:0] : EV_RESET;

   // combinational wait: two-cycle access with no read pipeline
   assign avs_waitrequest_out = bus_req & ~bus_fire;
   assign avs_readdata_out    = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   wire        any_mode_wr;
   wire [6:0]  mode_wdata;
   wire [2:0]  events;
   wire        clear_on_mode;
   wire        dzero_ev;

   assign any_mode_wr = mode_wr_in | wr_mode;
   assign mode_wdata  = mode_wr_in ? mode_data_in
                                   : avs_writedata_in[MODE_W-1:0];

   assign events[EV_DONE]  = do_op;
   assign events[EV_OVF]   = op_ovf;
   // op 0 clears as soon as the mode is written, no operand transfer
   assign clear_on_mode = any_mode_wr
                        & (mode_wdata[MODE_OP_MSB:MODE_OP_LSB] == OP_CLEAR);
   assign dzero_ev = do_op & is_div & dp.div_zero;
   assign events[EV_DZERO] = dzero_ev;

   always_comb
   begin
      mode_next   = any_mode_wr ? mode_wdata : mode_reg;
      result_next = result_reg;
      if (clear_on_mode)
      begin
         result_next = RESULT_RESET;
      end
      else if (do_op)
      begin
         if (is_div)
         begin
            result_next = {dp.rem, dp.quot};
         end
         else if (is_mac)
         begin
            result_next = dp.sum;
         end
         else if (is_mul)
         begin
            result_next = dp.prod;
         end
         // read mode and others leave the result alone
      end
      else if (do_load)
      begin
         if (is_load16)
         begin
            result_next = {16'h0000, src_opnd_in};
         end
         else if (is_load32)
         begin
            result_next = {dst_opnd_in, src_opnd_in};
         end
      end
   end

   always_comb
   begin
      ovf_next = ovf_reg;
      if (counts_for_ovf)
      begin
         ovf_next = op_ovf;
      end
   end

   // answer half taken from the updated result, so divide returns
   // quotient or residue and read mode returns the held value
   assign ans_data_next = high_sel ? result_next[31:16]
                                   : result_next[15:0];
   // only an overflowing accumulate raises a flag
   assign flags_next = op_ovf ? FLAGS_OVF : FLAGS_NONE;

   // set wins over a same-cycle clear
   assign status_next = (status_reg & ~clear_bits) | events;
   assign enable_next = wr_enable ? avs_writedata_in[EV_W-1:0] : enable_reg;

   // snapshot one cycle ahead of completion; a cpu strobe that stalls
   // the access lands after the snapshot, so the read sees older state
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (avs_read_in)
      begin
         if (hit_mode)
         begin
            rdata_next = {25'h000_0000, mode_reg};
         end
         else if (hit_result)
         begin
            rdata_next = result_reg;
         end
         else if (hit_status)
         begin
            rdata_next = {29'h0000_0000, status_reg};
         end
         else if (hit_enable)
         begin
            rdata_next = {29'h0000_0000, enable_reg};
         end
         else if (hit_state)
         begin
            rdata_next = {31'h0000_0000, ovf_reg};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clock_in)
   begin
      if (!rstn_in)
      begin
         mode_reg   <= MODE_RESET;
         result_reg <= RESULT_RESET;
         ovf_reg    <= 1'b0;
      end
      else
      begin
         mode_reg   <= mode_next;
         result_reg <= result_next;
         ovf_reg    <= ovf_next;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!rstn_in)
      begin
         ans_valid_reg <= 1'b0;
         ans_data_reg  <= 16'h0000;
         flags_reg     <= FLAGS_NONE;
      end
      else
      begin
         ans_valid_reg <= do_op;
         if (do_op)
         begin
            ans_data_reg <= ans_data_next;
            flags_reg    <= flags_next;
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!rstn_in)
      begin
         status_reg <= EV_RESET;
         enable_reg <= EV_RESET;
         ack_reg    <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
      end
      else
      begin
         status_reg <= status_next;
         enable_reg <= enable_next;
         // one wait state: data is captured, then the access completes
         ack_reg    <= bus_req & ~bus_fire;
         rdata_reg  <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign ans_valid_out = ans_valid_reg;
   assign ans_data_out  = ans_data_reg;
   assign flags_out     = flags_reg;
   // level built from flops only, so no decode glitch reaches the cpu
   assign irq_out       = |(status_reg & enable_reg);

endmodule : mdu_unit
`default_nettype wire

// File: bench/mdu_unit_assertions.sv
// port-level assertion checker for the multiplier/divider unit
`timescale 1ns/10ps
`default_nettype none
module mdu_unit_assertions
   import mdu_pkg::*;
(
   input wire logic        clock_in,
   input wire logic        rstn_in,
   input wire logic        mode_wr_in,
   input wire logic [6:0]  mode_data_in,
   input wire logic        operate_wr_in,
   input wire logic        load_wr_in,
   input wire logic [15:0] dst_opnd_in,
   input wire logic [15:0] src_opnd_in,
   input wire logic        ans_valid_out,
   input wire logic [15:0] ans_data_out,
   input wire logic [3:0]  flags_out,
   input wire logic [4:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        irq_out
);
   logic [6:0] mode_reg;
   wire logic bus_mode = avs_write_in && !avs_waitrequest_out
      && avs_address_in == ADDR_MODE && avs_byteenable_in[0];
   wire logic op_take = operate_wr_in && !mode_wr_in;
   wire logic [15:0] div_ans = (mode_reg[6:4] == OUT_HIGH)
      ? dst_opnd_in % src_opnd_in : dst_opnd_in / src_opnd_in;
   wire logic unmapped = avs_address_in == ADDR_CLEAR || !(avs_address_in
      inside {ADDR_MODE, ADDR_RESULT, ADDR_STATUS, ADDR_ENABLE, ADDR_STATE});
   wire logic cpu_busy = mode_wr_in || operate_wr_in || load_wr_in;
   wire logic bus_req = avs_read_in || avs_write_in;

   // shadow mode: the bus path writes it too, never with a cpu strobe
   always_ff @(posedge clock_in)
      if (!rstn_in)
         mode_reg <= MODE_RESET;
      else if (mode_wr_in)
         mode_reg <= mode_data_in;
      else if (bus_mode)
         mode_reg <= avs_writedata_in[6:0];

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   sequence s_div_op;
      op_take && mode_reg[3:0] == OP_DIVU && src_opnd_in != 16'h0000;
   endsequence
   sequence s_bus_start;
      $rose(bus_req) ##1 !cpu_busy;
   endsequence

   a_answer_next: assert property
      (op_take |=> ans_valid_out) else $error("operate gave no answer");
   a_answer_cause: assert property
      (ans_valid_out |-> $past(op_take))
      else $error("answer without operate");
   a_divide_half: assert property
      (s_div_op |=> ans_data_out == $past(div_ans))
      else $error("wrong division half returned");
   a_flags_clear: assert property
      (op_take && mode_reg[3:0] != OP_MAC |=> flags_out == FLAGS_NONE)
      else $error("flags not cleared");
   a_flags_only_v: assert property
      (ans_valid_out |-> (flags_out & ~FLAGS_OVF) == FLAGS_NONE)
      else $error("c z n set");
   // the past-reset term keeps a short mid-run reset from firing this
   a_answer_holds: assert property
      ($past(rstn_in) && !ans_valid_out
         |-> $stable(ans_data_out) && $stable(flags_out))
      else $error("answer changed without operate");
   a_wait_first: assert property ($rose(bus_req) |-> avs_waitrequest_out)
      else $error("bus access not stalled first cycle");
   a_wait_done: assert property (s_bus_start |-> !avs_waitrequest_out)
      else $error("bus access not done in two cycles");
   a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
      && unmapped |-> avs_readdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule : mdu_unit_assertions

bind mdu_unit mdu_unit_assertions mdu_unit_assertions_i (.clock_in, .rstn_in,
   .mode_wr_in, .mode_data_in, .operate_wr_in, .load_wr_in, .dst_opnd_in,
   .src_opnd_in, .ans_valid_out, .ans_data_out, .flags_out, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
   .avs_readdata_out, .avs_waitrequest_out, .irq_out);
`default_nettype wire

// File: bench/mdu_cpu_model.sv
// cpu core model issuing coprocessor transfers
`timescale 1ns/10ps
`default_nettype none
module mdu_cpu_model
(
   input  wire logic        clock_in,
   input  wire logic        ans_valid_in,
   input  wire logic [15:0] ans_data_in,
   input  wire logic [3:0]  flags_in,
   output logic             mode_wr_out,
   output logic [6:0]       mode_data_out,
   output logic             operate_wr_out,
   output logic             load_wr_out,
   output logic [15:0]      dst_out,
   output logic [15:0]      src_out
);
   int gap = 0;

   initial
   begin
      mode_wr_out = 1'b0;
      operate_wr_out = 1'b0;
      load_wr_out = 1'b0;
      mode_data_out = 7'h00;
      dst_out = 16'h0000;
      src_out = 16'h0000;
   end

   task automatic set_mode(input logic [6:0] m);
      @(posedge clock_in);
      mode_wr_out <= 1'b1;
      mode_data_out <= m;
      @(posedge clock_in);
      mode_wr_out <= 1'b0;
      mode_data_out <= ~m;
   endtask : set_mode

   // released operand lines show the inverse, never a stale value
   task automatic send(input logic is_op, input logic [15:0] d, s,
      output logic [15:0] a, output logic [3:0] f, output logic ok);
      int k;
      repeat (gap) @(posedge clock_in);
      @(posedge clock_in);
      operate_wr_out <= is_op;
      load_wr_out <= !is_op;
      dst_out <= d;
      src_out <= s;
      @(posedge clock_in);
      operate_wr_out <= 1'b0;
      load_wr_out <= 1'b0;
      dst_out <= ~d;
      src_out <= ~s;
      ok = !is_op;
      for (k = 0; k < 4 && !ok; k++)
      begin
         @(posedge clock_in);
         ok = ans_valid_in === 1'b1;
      end
      a = ans_data_in;
      f = flags_in;
   endtask : send
endmodule : mdu_cpu_model
`default_nettype wire

// File: bench/mdu_unit_tb.sv
// self-checking bench for the multiplier/divider unit
`timescale 1ns/10ps
`default_nettype none
module mdu_unit_tb;
   import mdu_pkg::*;
   logic             clock_in, rstn_in, avs_read_in, avs_write_in;
   logic [4:0]       avs_address_in;
   logic [31:0]      avs_writedata_in;
   logic [3:0]       avs_byteenable_in;
   wire logic        mode_wr_in, operate_wr_in, load_wr_in, ans_valid_out;
   wire logic        avs_waitrequest_out, irq_out;
   wire logic [6:0]  mode_data_in;
   wire logic [15:0] dst_opnd_in, src_opnd_in, ans_data_out;
   wire logic [3:0]  flags_out;
   wire logic [31:0] avs_readdata_out;
   int               err_total = 0;
   int               n_tests = 0;
   logic [4:0]       map [7] = '{ADDR_MODE, ADDR_RESULT, ADDR_STATUS,
      ADDR_CLEAR, ADDR_ENABLE, ADDR_STATE, 5'h18};

   mdu_unit mdu_unit_i (.clock_in, .rstn_in, .mode_wr_in, .mode_data_in,
      .operate_wr_in, .load_wr_in, .dst_opnd_in, .src_opnd_in, .ans_valid_out,
      .ans_data_out, .flags_out, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
      .avs_waitrequest_out, .irq_out);
   mdu_cpu_model cpu_i (.clock_in, .ans_valid_in(ans_valid_out),
      .ans_data_in(ans_data_out), .flags_in(flags_out),
      .mode_wr_out(mode_wr_in), .mode_data_out(mode_data_in),
      .operate_wr_out(operate_wr_in), .load_wr_out(load_wr_in),
      .dst_out(dst_opnd_in), .src_out(src_opnd_in));

   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   task automatic timeout;
      err_total++;
      $display("BAD wait limit exp 0 seen 1");
      end_of_test();
   endtask : timeout

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int k = 0;
      @(posedge clock_in);
      avs_read_in <= !wr;
      avs_write_in <= wr;
      avs_address_in <= a;
      avs_writedata_in <= d;
      do
      begin
         @(posedge clock_in);
         k++;
      end
      while (avs_waitrequest_out !== 1'b0 && k < 20);
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (k >= 20)
         timeout();
   endtask : bus

   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(nm, q, e);
   endtask : rd

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic op(input logic [15:0] d, s, ea, input logic [3:0] ef);
      logic [15:0] a;
      logic [3:0]  f;
      logic        ok;
      cpu_i.send(1'b1, d, s, a, f, ok);
      if (ok)
      begin
         chk("answer", {16'h0000, a}, {16'h0000, ea});
         chk("flags", {28'h000_0000, f}, {28'h000_0000, ef});
      end
      else
         timeout();
   endtask : op

   task automatic ld(input logic [15:0] d, s);
      logic [15:0] a;
      logic [3:0]  f;
      logic        ok;
      cpu_i.send(1'b0, d, s, a, f, ok);
   endtask : ld

   // enable and clear land at the completion edge, so look one edge later
   task automatic irq(input logic e);
      @(posedge clock_in);
      chk("irq", {31'h0000_0000, irq_out}, {31'h0000_0000, e});
   endtask : irq

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rstn_in = 1'b0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_address_in = 5'h00;
      avs_writedata_in = 32'h0000_0000;
      avs_byteenable_in = 4'hf;
      repeat (12) @(posedge clock_in);
      rstn_in <= 1'b1;
      foreach (map[i]) rd(map[i], 32'h0000_0000, "reset");
      $display("test reset done");
      cpu_i.set_mode(7'h08);
      op(16'h0064, 16'h0007, 16'h000e, FLAGS_NONE);
      cpu_i.set_mode(7'h13);
      op(16'h0000, 16'h0000, 16'h0002, FLAGS_NONE);
      rd(ADDR_RESULT, 32'h0002_000e, "div result");
      cpu_i.set_mode(7'h19);
      op(16'hff9c, 16'h0007, 16'hfffe, FLAGS_NONE);
      cpu_i.set_mode(7'h03);
      op(16'h0000, 16'h0000, 16'hfff2, FLAGS_NONE);
      $display("test divide done");
      cpu_i.set_mode(7'h01);
      ld(16'h1234, 16'h5678);
      rd(ADDR_RESULT, 32'h0000_5678, "load16");
      cpu_i.set_mode(7'h02);
      ld(16'h1234, 16'h5678);
      rd(ADDR_RESULT, 32'h1234_5678, "load32");
      cpu_i.set_mode(7'h00);
      rd(ADDR_RESULT, 32'h0000_0000, "clear");
      $display("test init done");
      cpu_i.gap = 2;
      cpu_i.set_mode(7'h02);
      ld(16'h7fff, 16'hfff0);
      cpu_i.set_mode(7'h17);
      op(16'h0001, 16'h0010, 16'h8000, FLAGS_OVF);
      rd(ADDR_STATE, 32'h0000_0001, "ovf set");
      op(16'hffff, 16'h0001, 16'h7fff, FLAGS_OVF);
      op(16'h0000, 16'h0000, 16'h7fff, FLAGS_NONE);
      rd(ADDR_STATE, 32'h0000_0000, "ovf clean");
      cpu_i.set_mode(7'h07);
      op(16'h0002, 16'h0003, 16'h0005, FLAGS_OVF);
      $display("test accumulate done");
      wr(ADDR_ENABLE, 32'h0000_0002);
      rd(ADDR_STATUS, 32'h0000_0003, "status");
      irq(1'b1);
      wr(ADDR_ENABLE, 32'h0000_0000);
      irq(1'b0);
      wr(ADDR_ENABLE, 32'h0000_0002);
      cpu_i.set_mode(7'h03);
      rd(ADDR_STATE, 32'h0000_0001, "ovf kept");
      op(16'h0000, 16'h0000, 16'h0005, FLAGS_NONE);
      rd(ADDR_STATE, 32'h0000_0001, "ovf read mode");
      cpu_i.set_mode(7'h01);
      ld(16'h1111, 16'h2222);
      rd(ADDR_STATE, 32'h0000_0000, "ovf load");
      rd(ADDR_RESULT, 32'h0000_2222, "load16 again");
      irq(1'b1);
      wr(ADDR_CLEAR, 32'h0000_0002);
      rd(ADDR_STATUS, 32'h0000_0001, "status clear");
      irq(1'b0);
      $display("test irq done");
      // full-width products catch a product cut to 16 bits
      cpu_i.set_mode(7'h14);
      op(16'hffff, 16'h0002, 16'h0001, FLAGS_NONE);
      cpu_i.set_mode(7'h15);
      op(16'hffff, 16'h0002, 16'hffff, FLAGS_NONE);
      cpu_i.set_mode(7'h00);
      cpu_i.set_mode(7'h17);
      op(16'h0100, 16'h0100, 16'h0001, FLAGS_NONE);
      op(16'hff00, 16'h0100, 16'h0000, FLAGS_NONE);
      cpu_i.set_mode(7'h18);
      op(16'h0064, 16'h0000, 16'h0064, FLAGS_NONE);
      rd(ADDR_STATUS, 32'h0000_0005, "status dzero");
      avs_byteenable_in <= 4'he;
      wr(ADDR_ENABLE, 32'h0000_0007);
      avs_byteenable_in <= 4'h1;
      rd(ADDR_ENABLE, 32'h0000_0002, "enable lane 0");
      wr(ADDR_ENABLE, 32'h0000_0004);
      irq(1'b1);
      $display("test extra modes done");
      end_of_test();
   end
endmodule : mdu_unit_tb
`default_nettype wire
